// >>> hall_phase_map.vh
// Register map, field positions, reset values and signal state word layout of the Hall phase initializer.
// Assumes a 32-bit APB bus; each axis occupies a block of eight words.
`ifndef HALL_PHASE_MAP_VH
`define HALL_PHASE_MAP_VH

// Register word index inside one axis block; byte address is four times it
`define REG_CTRL 3'h0
`define REG_STATUS 3'h1
`define REG_POLARITY 3'h2
`define REG_SIGNAL_STATE 3'h3
`define REG_COUNTS_PER_CYCLE 3'h4
`define REG_COUNTS_PER_REV 3'h5
`define REG_PHASE_OFFSET 3'h6
`define REG_ANGLE 3'h7
// Axis select bit in the byte address
`define AXIS_SEL_BIT 5

// Control register fields
`define CTRL_MODE_BIT 0
`define CTRL_TRIG_BIT 1
`define MODE_ALGORITHMIC 1'b0
`define MODE_HALL 1'b1

// Status register fields
`define STAT_DONE_BIT 0
`define STAT_SIN_BIT 1
`define STAT_ERR_BIT 2
`define STAT_VALID_BIT 3

// Signal state word layout
`define SIG_ENC_A 0
`define SIG_ENC_B 1
`define SIG_ENC_IDX 2
`define SIG_LIM_POS 4
`define SIG_LIM_NEG 5
`define SIG_AUX 6
`define SIG_HALL_A 7
`define SIG_HALL_B 8
`define SIG_HALL_C 9
`define SIG_ONE 10
`define POL_MASK 16'h03F7

// Reset values
`define POL_RST 16'h0000
`define CPC_RST 16'h0400
`define CPR_RST 16'h1000
`define OFFSET_NONE 16'hFFFF

`endif

// >>> hall_axis_core.v
// One axis: quadrature tracking, Hall-based phase set, rotation check and index offset capture.
// Assumes conditioned, same-clock inputs and a one-cycle trigger pulse.
`timescale 1ns/1ps
`include "hall_phase_map.vh"

module hall_axis_core (
   // Clock and reset
   input wire clk_sys,
   input wire rst_b,
   // Conditioned motor-side inputs
   input wire [2:0] hallSector,
   input wire hallValid,
   input wire encA,
   input wire encB,
   input wire encIdx,
   // Host controls
   input wire initMode,
   input wire initTrig,
   input wire errClr,
   input wire [15:0] countsPerCycle,
   input wire [15:0] countsPerRev,
   // Results
   output reg [15:0] angle_q,
   output reg [15:0] offset_q,
   output reg [15:0] position_q,
   output reg initDone_q,
   output reg sinActive_q,
   output reg hallErr_q,
   output reg algStart_q
);

   reg encAPrev_q;
   reg encBPrev_q;
   reg idxPrev_q;
   reg [2:0] sectorPrev_q;
   reg [16:0] travel_q;
   reg [15:0] angle_d;
   reg [16:0] travelAbs;
   wire stepEn;
   wire stepUp;
   wire tracking;
   wire [2:0] sectorNext;
   wire [2:0] sectorBack;

   // Start of a 60 degree sector within the electrical cycle
   function [15:0] sector_base;
      input [15:0] cpc;
      input [2:0] s;
      reg [18:0] p;
      reg [18:0] q;
      begin
         p = {3'b000, cpc} * {16'h0000, s};
         q = p / 19'h00006;
         sector_base = q[15:0];
      end
   endfunction

   // Middle of a sector, used when only the sector is known
   function [15:0] sector_center;
      input [15:0] cpc;
      input [2:0] s;
      reg [19:0] p;
      reg [19:0] q;
      begin
         p = {4'h0, cpc} * {16'h0000, s, 1'b1};
         q = p / 20'h0000C;
         sector_center = q[15:0];
      end
   endfunction

   assign stepEn = (encA ^ encAPrev_q) ^ (encB ^ encBPrev_q);
   assign stepUp = encA ^ encBPrev_q;
   assign tracking = initDone_q & (initMode == `MODE_HALL) & ~sinActive_q;
   assign sectorNext = (sectorPrev_q == 3'h5) ? 3'h0 : sectorPrev_q + 3'h1;
   assign sectorBack = (sectorPrev_q == 3'h0) ? 3'h5 : sectorPrev_q - 3'h1;

   always @* begin
      travelAbs = travel_q[16] ? (~travel_q + 17'h00001) : travel_q;
      angle_d = angle_q;
      if (countsPerCycle == 16'h0000) begin
         angle_d = 16'h0000;
      end else if (initTrig && initMode == `MODE_HALL && hallValid) begin
         angle_d = sector_center(countsPerCycle, hallSector); // RULE1 RULE4
      end else if (tracking && hallValid && hallSector == sectorNext) begin
         angle_d = sector_base(countsPerCycle, hallSector); // RULE10
      end else if (tracking && hallValid && hallSector == sectorBack) begin
         angle_d = (sector_base(countsPerCycle, sectorPrev_q) == 16'h0000) ?
            countsPerCycle - 16'h0001 :
            sector_base(countsPerCycle, sectorPrev_q) - 16'h0001; // RULE10
      end else if (stepEn && stepUp) begin
         angle_d = (angle_q >= countsPerCycle - 16'h0001) ? 16'h0000 : angle_q + 16'h0001; // RULE14
      end else if (stepEn) begin
         angle_d = (angle_q == 16'h0000 || angle_q >= countsPerCycle) ?
            countsPerCycle - 16'h0001 : angle_q - 16'h0001; // RULE14
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         encAPrev_q <= 1'b0;
         encBPrev_q <= 1'b0;
         idxPrev_q <= 1'b0;
         sectorPrev_q <= 3'h0;
         travel_q <= 17'h00000;
         angle_q <= 16'h0000;
         offset_q <= `OFFSET_NONE;
         position_q <= 16'h0000;
         initDone_q <= 1'b0;
         sinActive_q <= 1'b0;
         hallErr_q <= 1'b0;
         algStart_q <= 1'b0;
      end else begin
         encAPrev_q <= encA;
         encBPrev_q <= encB;
         idxPrev_q <= encIdx;
         if (hallValid) begin
            sectorPrev_q <= hallSector;
         end
         angle_q <= angle_d;
         if (stepEn) begin
            position_q <= stepUp ? position_q + 16'h0001 : position_q - 16'h0001;
         end
         algStart_q <= initTrig & (initMode == `MODE_ALGORITHMIC);
         if (initTrig && initMode == `MODE_HALL && hallValid) begin
            initDone_q <= 1'b1; // RULE4
            sinActive_q <= 1'b0;
            travel_q <= 17'h00000;
         end else if (tracking) begin
            if (travelAbs >= {1'b0, countsPerRev}) begin
               sinActive_q <= 1'b1; // RULE2
            end else if (stepEn) begin
               travel_q <= stepUp ? travel_q + 17'h00001 : travel_q - 17'h00001; // RULE2
            end
         end
         if (initTrig && initMode == `MODE_HALL && !hallValid) begin
            hallErr_q <= 1'b1; // RULE15
         end else if (errClr) begin
            hallErr_q <= 1'b0;
         end
         if (encIdx && !idxPrev_q) begin
            offset_q <= (angle_q == 16'h0000) ? 16'h0000 : countsPerCycle - angle_q; // RULE9
         end else if (initTrig) begin
            offset_q <= `OFFSET_NONE; // RULE12
         end
      end
   end

endmodule // hall_axis_core

// >>> hall_phase_initializer.v
// Two-axis Hall phase initializer with APB register access, input sense and signal state word.
// Assumes motor-side pins are asynchronous and an APB master on clk_sys.
// What this block does
// RULE1: Hall mode takes the initial phase from the axis's three Hall inputs.
// RULE2: After Hall init, sinusoidal commutation starts once one full rotation is travelled.
// RULE3: Every axis has its own Hall A to C inputs, readable in signal state.
// RULE4: Trigger in Hall mode sets the phase at once, with no motion needed.
// RULE5: A writable, readable polarity word sets each input active high or low.
// RULE6: System uses Hall init only with three phases and 120 degree sensors.
// RULE7: Forward rotation steps the state word through 6F 4F 5F 57 77 67.
// RULE8: Limit and auxiliary inputs are in the word; low gives 68 48 58 50 70 60.
// RULE9: Phase offset gives electrical cycle start relative to index, stable across inits.
// RULE10: Hall transitions land at fixed cycle points; forward means increasing position.
// RULE11: Mode code 0 selects algorithmic, code 1 selects Hall-based initialization.
// RULE12: Phase offset reads 65535 while no index has been captured.
// RULE13: Polarity 0x380 inverts all three Hall inputs, a 180 degree shift.
// RULE14: Host programs encoder counts per electrical cycle before initialization.
// RULE15: Six Hall states map to 60 degree sectors; all zero and all one are invalid.
`timescale 1ns/1ps
`include "hall_phase_map.vh"

module hall_phase_initializer (
   // Clock and reset
   input wire clk_sys,
   input wire rst_b,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_q,
   output reg pready_q,
   output reg pslverr_q,
   // Motor-side pins, bit 0 axis 1, bit 1 axis 2
   input wire [1:0] hallA,
   input wire [1:0] hallB,
   input wire [1:0] hallC,
   input wire [1:0] limitPos,
   input wire [1:0] limitNeg,
   input wire [1:0] auxIn,
   input wire [1:0] encA,
   input wire [1:0] encB,
   input wire [1:0] encIdx,
   // Commutation outputs
   output wire [31:0] commAngle,
   output wire [1:0] sinActive,
   output wire [1:0] algStart
);

   reg [17:0] sync1_q;
   reg [17:0] sync2_q;
   wire [17:0] pinsRaw;
   wire accessPhase;
   wire addrOk;
   wire wrEn;
   wire axisSel;
   wire [2:0] regIdx;
   wire [31:0] ctrlRd;
   wire [31:0] statusRd;
   wire [31:0] polRd;
   wire [31:0] sigRd;
   wire [31:0] cpcRd;
   wire [31:0] cprRd;
   wire [31:0] offRd;
   wire [31:0] angRd;
   reg [31:0] rdMux;

   // Hall code {C,B,A} to forward sector index, bit 3 marks a valid code
   function [3:0] hall_sector;
      input [2:0] cba;
      begin
         case (cba)
            3'h5: hall_sector = 4'h8;
            3'h1: hall_sector = 4'h9;
            3'h3: hall_sector = 4'hA;
            3'h2: hall_sector = 4'hB;
            3'h6: hall_sector = 4'hC;
            3'h4: hall_sector = 4'hD;
            default: hall_sector = 4'h0; // RULE15
         endcase
      end
   endfunction

   // Two-stage synchronisers for every pin
   assign pinsRaw = {encIdx, encB, encA, auxIn, limitNeg, limitPos, hallC, hallB, hallA};

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 18'h00000;
         sync2_q <= 18'h00000;
      end else begin
         sync1_q <= pinsRaw;
         sync2_q <= sync1_q;
      end
   end

   // APB decode; one wait state, write commits with pready
   assign accessPhase = psel & penable & ~pready_q;
   assign addrOk = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00);
   assign wrEn = psel & penable & pready_q & pwrite & addrOk;
   assign axisSel = paddr[`AXIS_SEL_BIT];
   assign regIdx = paddr[4:2];

   genvar a;
   generate
      for (a = 0; a < 2; a = a + 1) begin : gAxis
         reg mode_q;
         reg trig_q;
         reg errClr_q;
         reg [15:0] polarity_q;
         reg [15:0] cpc_q;
         reg [15:0] cpr_q;
         wire [15:0] rawWord;
         wire [15:0] sigWord;
         wire [3:0] sect;
         wire [15:0] angleW;
         wire [15:0] offsetW;
         wire [15:0] posW;
         wire doneW;
         wire sinW;
         wire errW;
         wire axisWr;

         assign rawWord = {5'h00, 1'b1, sync2_q[4 + a], sync2_q[2 + a], sync2_q[0 + a],
            sync2_q[10 + a], sync2_q[8 + a], sync2_q[6 + a], 1'b0,
            sync2_q[16 + a], sync2_q[14 + a], sync2_q[12 + a]}; // RULE3 RULE7 RULE8
         assign sigWord = rawWord ^ (polarity_q & `POL_MASK); // RULE5 RULE13
         assign sect = hall_sector({sigWord[`SIG_HALL_C], sigWord[`SIG_HALL_B],
            sigWord[`SIG_HALL_A]}); // RULE1
         assign axisWr = wrEn & (axisSel == a);

         always @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               mode_q <= `MODE_ALGORITHMIC;
               trig_q <= 1'b0;
               errClr_q <= 1'b0;
               polarity_q <= `POL_RST;
               cpc_q <= `CPC_RST;
               cpr_q <= `CPR_RST;
            end else begin
               trig_q <= axisWr & (regIdx == `REG_CTRL) & pwdata[`CTRL_TRIG_BIT];
               errClr_q <= axisWr & (regIdx == `REG_STATUS) & pwdata[`STAT_ERR_BIT];
               if (axisWr && regIdx == `REG_CTRL) begin
                  mode_q <= pwdata[`CTRL_MODE_BIT]; // RULE11
               end
               if (axisWr && regIdx == `REG_POLARITY) begin
                  polarity_q <= pwdata[15:0] & `POL_MASK; // RULE5
               end
               if (axisWr && regIdx == `REG_COUNTS_PER_CYCLE) begin
                  cpc_q <= pwdata[15:0]; // RULE14
               end
               if (axisWr && regIdx == `REG_COUNTS_PER_REV) begin
                  cpr_q <= pwdata[15:0];
               end
            end
         end

         hall_axis_core uCore (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .hallSector(sect[2:0]),
            .hallValid(sect[3]),
            .encA(sigWord[`SIG_ENC_A]),
            .encB(sigWord[`SIG_ENC_B]),
            .encIdx(sigWord[`SIG_ENC_IDX]),
            .initMode(mode_q),
            .initTrig(trig_q),
            .errClr(errClr_q),
            .countsPerCycle(cpc_q),
            .countsPerRev(cpr_q),
            .angle_q(angleW),
            .offset_q(offsetW),
            .position_q(posW),
            .initDone_q(doneW),
            .sinActive_q(sinW),
            .hallErr_q(errW),
            .algStart_q(algStart[a])
         );

         assign commAngle[16 * a + 15:16 * a] = angleW;
         assign sinActive[a] = sinW;
         assign ctrlRd[16 * a + 15:16 * a] = {15'h0000, mode_q};
         assign statusRd[16 * a + 15:16 * a] = {12'h000, sect[3], errW, sinW, doneW};
         assign polRd[16 * a + 15:16 * a] = polarity_q;
         assign sigRd[16 * a + 15:16 * a] = sigWord; // RULE3
         assign cpcRd[16 * a + 15:16 * a] = cpc_q;
         assign cprRd[16 * a + 15:16 * a] = cpr_q;
         assign offRd[16 * a + 15:16 * a] = offsetW; // RULE9 RULE12
         assign angRd[16 * a + 15:16 * a] = angleW;
      end
   endgenerate

   // Read multiplexer; angle word carries position in its upper half
   always @* begin
      rdMux = 32'h00000000;
      case (regIdx)
         `REG_CTRL: rdMux = {16'h0000, axisSel ? ctrlRd[31:16] : ctrlRd[15:0]};
         `REG_STATUS: rdMux = {16'h0000, axisSel ? statusRd[31:16] : statusRd[15:0]};
         `REG_POLARITY: rdMux = {16'h0000, axisSel ? polRd[31:16] : polRd[15:0]};
         `REG_SIGNAL_STATE: rdMux = {16'h0000, axisSel ? sigRd[31:16] : sigRd[15:0]};
         `REG_COUNTS_PER_CYCLE: rdMux = {16'h0000, axisSel ? cpcRd[31:16] : cpcRd[15:0]};
         `REG_COUNTS_PER_REV: rdMux = {16'h0000, axisSel ? cprRd[31:16] : cprRd[15:0]};
         `REG_PHASE_OFFSET: rdMux = {16'h0000, axisSel ? offRd[31:16] : offRd[15:0]};
         `REG_ANGLE: rdMux = {axisSel ? gAxis[1].posW : gAxis[0].posW,
            axisSel ? angRd[31:16] : angRd[15:0]};
         default: rdMux = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= accessPhase;
         if (accessPhase) begin
            prdata_q <= (addrOk && !pwrite) ? rdMux : 32'h00000000;
            pslverr_q <= ~addrOk;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

endmodule // hall_phase_initializer

// >>> hall_motor_model.sv
// Behavioural Hall sensors and quadrature encoder of one motor axis.
// Assumes step pulses spaced several clk_sys cycles apart.
`timescale 1ns/1ps
module hall_motor_model (
   // Commands
   input wire clk_sys,
   input wire step,
   input wire fault,
   // Sensors
   output wire hallA,
   output wire hallB,
   output wire hallC,
   output wire encA,
   output wire encB,
   output wire encIdx
);
   reg [7:0] pos_q = 8'h00;
   reg [2:0] idx_q = 3'h0;
   reg [2:0] code;
   always @* begin
      case (pos_q % 8'd12)
         8'd0, 8'd1: code = 3'h5;
         8'd2, 8'd3: code = 3'h1;
         8'd4, 8'd5: code = 3'h3;
         8'd6, 8'd7: code = 3'h2;
         8'd8, 8'd9: code = 3'h6;
         default: code = 3'h4;
      endcase
      if (fault) code = 3'h0;
   end
   assign {hallC, hallB, hallA} = code;
   assign encA = pos_q[1] ^ pos_q[0];
   assign encB = pos_q[1];
   // Index lags the step so the angle has settled
   assign encIdx = idx_q[2];
   always @(posedge clk_sys) begin
      if (step) pos_q <= pos_q + 8'h01;
      idx_q <= {idx_q[1:0], pos_q % 8'd24 == 8'd8};
   end
endmodule // hall_motor_model

// >>> hall_phase_initializer_monitor.sv
// Checker on the APB side and axis 1 outputs of the Hall phase initializer.
// Assumes a master that holds each request until pready_q.
`timescale 1ns/1ps
module hall_phase_initializer_monitor (
   // Clock and reset
   input wire clk_sys,
   input wire rst_b,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata_q,
   input wire pready_q,
   input wire pslverr_q,
   // Axis outputs
   input wire [1:0] sinActive,
   input wire [1:0] algStart
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire fin = psel && penable && pready_q;
   wire bad = paddr[7:6] != 2'h0 || paddr[1:0] != 2'h0;
   wire trig = fin && pwrite && paddr == 8'h00 && pwdata[1];
   a_ready_wait: assert property ((psel && !penable) ##1 (psel && penable)
      |-> !pready_q ##1 pready_q) else $error("pready not after one wait");
   a_ready_pulse: assert property (pready_q |=> !pready_q) else $error("pready too long");
   a_err_ready: assert property (pslverr_q |-> pready_q) else $error("pslverr alone");
   a_bad_err: assert property (fin && bad |-> pslverr_q) else $error("no error");
   a_good_ok: assert property (fin && !bad |-> !pslverr_q) else $error("spurious error");
   a_err_zero: assert property (pslverr_q |-> prdata_q == 32'h0) else $error("data on error");
   a_alg_cause: assert property ($rose(algStart[0]) |-> $past(trig && !pwdata[0], 2))
      else $error("algStart without trigger");
   a_hall_quiet: assert property (trig && pwdata[0] |-> ##1 !algStart[0] [*3])
      else $error("motion start in Hall mode");
   a_sin_restart: assert property (trig && pwdata[0] |-> ##2 !sinActive[0])
      else $error("sinusoidal kept after trigger");
endmodule // hall_phase_initializer_monitor

bind hall_phase_initializer hall_phase_initializer_monitor i_mon (.clk_sys(clk_sys),
   .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
   .sinActive(sinActive), .algStart(algStart));

// >>> hall_phase_initializer_tb.sv
// Self-checking bench for the Hall phase initializer over APB.
// Assumes a motor model on each axis and the bound checker.
`timescale 1ns/1ps
`include "hall_phase_map.vh"
module hall_phase_initializer_tb;
   localparam [47:0] FWD = 48'h684858507060;
   reg clk_sys = 1'b0;
   reg rst_b = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   reg [1:0] step = 2'h0;
   reg fault = 1'b0;
   reg [1:0] lim = 2'h0;
   reg [31:0] rdata;
   reg rerr;
   reg [15:0] off;
   integer numErrors = 0;
   integer nTests = 0;
   wire [31:0] prdata_q, commAngle;
   wire pready_q, pslverr_q;
   wire [1:0] hallA, hallB, hallC, encA, encB, encIdx, sinActive, algStart;
   hall_phase_initializer i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .hallA(hallA),
      .hallB(hallB), .hallC(hallC), .limitPos(lim), .limitNeg(lim), .auxIn(lim),
      .encA(encA), .encB(encB), .encIdx(encIdx), .commAngle(commAngle),
      .sinActive(sinActive), .algStart(algStart));
   hall_motor_model i_ax1 (.clk_sys(clk_sys), .step(step[0]), .fault(fault),
      .hallA(hallA[0]), .hallB(hallB[0]), .hallC(hallC[0]), .encA(encA[0]),
      .encB(encB[0]), .encIdx(encIdx[0]));
   hall_motor_model i_ax2 (.clk_sys(clk_sys), .step(step[1]), .fault(1'b0),
      .hallA(hallA[1]), .hallB(hallB[1]), .hallC(hallC[1]), .encA(encA[1]),
      .encB(encB[1]), .encIdx(encIdx[1]));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   task end_sim;
      begin
         $display("checks %0d, errors %0d", nTests, numErrors);
         if (numErrors == 0 && nTests > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task check(input [31:0] got, input [31:0] exp);
      begin
         nTests = nTests + 1;
         if (got !== exp) begin
            numErrors = numErrors + 1;
            $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      integer i;
      begin
         @(posedge clk_sys);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk_sys);
         penable <= 1'b1;
         i = 0;
         do begin
            @(posedge clk_sys);
            i = i + 1;
         end while (pready_q !== 1'b1 && i < 20);
         if (pready_q !== 1'b1) begin
            numErrors = numErrors + 1;
            $display("unexpected at %0t: no pready", $time);
            end_sim;
         end
         rdata = prdata_q;
         rerr = pslverr_q;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rdchk(input [7:0] a, input [31:0] m, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         check(rdata & m, e);
      end
   endtask
   task stepN(input integer n);
      begin
         repeat (n) begin
            @(posedge clk_sys) step[0] <= 1'b1;
            @(posedge clk_sys) step[0] <= 1'b0;
            repeat (6) @(posedge clk_sys);
         end
      end
   endtask
   task t_reset;
      begin
         rdchk(8'h08, 32'hFFFF, `POL_RST);
         rdchk(8'h30, 32'hFFFF, `CPC_RST);
         rdchk(8'h14, 32'hFFFF, `CPR_RST);
         rdchk(8'h18, 32'hFFFF, `OFFSET_NONE);
         apb(1'b0, 8'h41, 32'h0);
         check(rerr, 1'b1);
         check(rdata, 32'h0);
      end
   endtask
   task t_sequence;
      integer s;
      begin
         for (s = 0; s < 6; s = s + 1) begin
            rdchk(8'h0C, 32'hFF0, {FWD[47 - 8 * s -: 8], 4'h0});
            lim <= 2'h3;
            repeat (4) @(posedge clk_sys);
            rdchk(8'h0C, 32'hFF0, {FWD[47 - 8 * s -: 8] | 8'h07, 4'h0});
            rdchk(8'h2C, 32'hFF0, 32'h6F0);
            lim <= 2'h0;
            stepN(2);
         end
      end
   endtask
   task t_polarity;
      begin
         apb(1'b1, 8'h08, 32'h380);
         rdchk(8'h08, 32'hFFFF, 32'h380);
         rdchk(8'h0C, 32'hFF0, 32'h500);
         apb(1'b1, 8'h08, 32'hFFFF);
         rdchk(8'h08, 32'hFFFF, `POL_MASK);
         apb(1'b1, 8'h08, 32'h0);
      end
   endtask
   task t_hall_init;
      integer s;
      begin
         apb(1'b1, 8'h10, 32'd12);
         apb(1'b1, 8'h14, 32'd24);
         for (s = 0; s < 6; s = s + 1) begin
            apb(1'b1, 8'h00, 32'h3);
            rdchk(8'h1C, 32'hFFFF, 2 * s + 1);
            check(commAngle, 2 * s + 1);
            rdchk(8'h04, 32'hF, 32'h9);
            rdchk(8'h00, 32'h3, 32'h1);
            stepN(2);
         end
      end
   endtask
   task t_invalid;
      begin
         fault <= 1'b1;
         repeat (4) @(posedge clk_sys);
         apb(1'b1, 8'h00, 32'h3);
         rdchk(8'h04, 32'hC, 32'h4);
         apb(1'b1, 8'h04, 32'h4);
         rdchk(8'h04, 32'h4, 32'h0);
         fault <= 1'b0;
      end
   endtask
   task t_rotation;
      begin
         apb(1'b1, 8'h00, 32'h3);
         stepN(23);
         check(sinActive[0], 1'b0);
         stepN(1);
         check(sinActive[0], 1'b1);
         check(sinActive[1], 1'b0);
         apb(1'b0, 8'h18, 32'h0);
         off = rdata[15:0];
         check(off < 16'd12, 1'b1);
         stepN(2);
         apb(1'b1, 8'h00, 32'h3);
         rdchk(8'h18, 32'hFFFF, `OFFSET_NONE);
         check(sinActive[0], 1'b0);
         stepN(8);
         rdchk(8'h18, 32'hFFFF, off);
      end
   endtask
   task t_alg;
      integer ax, i;
      begin
         for (ax = 0; ax < 2; ax = ax + 1) begin
            apb(1'b1, ax[0] ? 8'h20 : 8'h00, 32'h2);
            i = 0;
            while (algStart[ax] !== 1'b1 && i < 8) begin
               @(posedge clk_sys);
               i = i + 1;
            end
            check(algStart[ax], 1'b1);
            rdchk(ax[0] ? 8'h20 : 8'h00, 32'h3, 32'h0);
         end
      end
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset;
      t_sequence;
      t_polarity;
      t_hall_init;
      t_invalid;
      t_rotation;
      t_alg;
      end_sim;
   end
endmodule // hall_phase_initializer_tb
